// [hw/uart_mp_params.svh]
// constants for the multiprocessor serial receiver/transmitter
`ifndef UART_MP_PARAMS_SVH
`define UART_MP_PARAMS_SVH

// register offsets on the plain register port
`define REG_CTRL 8'h00
`define REG_STAT 8'h01
`define REG_TXDATA 8'h02
`define REG_RXDATA 8'h03

// serial_control_one field positions
`define CTL_WORD9 0
`define CTL_PCE 1
`define CTL_ODD 2
`define CTL_WAKE 3
`define CTL_MUTE 4
`define CTL_PIE 5
`define CTL_RIE 6
`define CTL_IIE 7
`define CTL_RESET 8'h00

// serial_status_reg field positions (0..4 sticky, write one to clear)
`define ST_RX_DATA_READY_FLAG 0
`define ST_IDLE 1
`define ST_PERR 2
`define ST_OVR 3
`define ST_FERR 4
`define ST_TXEMPTY 5
`define ST_TXDONE 6
`define ST_RXBUSY 7
`define FLAGS_RESET 5'h00

// data field top index for 8 and 9 bit fields
`define TOP_8 4'h7
`define TOP_9 4'h8
// start plus stop bits around the field
`define FRAME_EXTRA 4'h2

// bus widths and defaults
`define ADDR_W 8
`define BUS_W 16
`define WORD_W 9
`define BIT_CYCLES_DEF 16
`define TXF_DEPTH_DEF 8

`endif

// [hw/uart_mp_pkg.sv]
// state types for the multiprocessor serial block
`default_nettype none
package uart_mp_pkg;
    // receive sequence, gray coded along the frame
    typedef enum logic [1:0] {
        RX_IDLE = 2'h0,
        RX_START = 2'h1,
        RX_DATA = 2'h3,
        RX_STOP = 2'h2
    } rx_state_t;
    // transmit sequence
    typedef enum logic {
        TX_IDLE = 1'h0,
        TX_SHIFT = 1'h1
    } tx_state_t;
endpackage
`default_nettype wire

// [hw/uart_tx_fifo.sv]
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module uart_tx_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH]; // storage words
    logic [AW-1:0] wr_ptr_q; // next slot to fill
    logic [AW-1:0] rd_ptr_q; // oldest word
    logic [CW-1:0] count_q; // words held
    logic push; // accepted write
    logic pop; // accepted read

    // honest full and empty straight from the count
    assign in_ready = (count_q != CNT_FULL);
    assign out_valid = (count_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_ptr_q];

    // storage has no reset, only written on push
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    // pointers wrap at depth, which need not be a power of two
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PTR_LAST) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == PTR_LAST) ? '0 : rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [hw/uart_mute_parity.sv]
// serial receiver/transmitter with receiver mute, wake-up and parity
//
// How it works
// - software mute request puts receiver asleep
// - no reception status flag sets while muted
// - receive interrupt requests suppressed while muted
// - wake select: idle line or address mark
// - idle wake clears mute, sets no idle flag
// - address mark wakes, clears mute, sets ready
// - address mark tests data msb, not parity
// - parity enable drives generation and checking
// - frame: start, data, optional parity, stop
// - parity select zero gives even parity
// - parity select one gives odd parity
// - transmitter replaces msb with parity bit
// - parity failure sets flag, interrupt if enabled
// - halt freezes serial logic until exit
`timescale 1ns/1ps
`default_nettype none
`include "uart_mp_params.svh"
module uart_mute_parity #(
    parameter int BIT_CYCLES = `BIT_CYCLES_DEF,
    parameter int FIFO_DEPTH = `TXF_DEPTH_DEF
) (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic [`ADDR_W-1:0] ADDR,
    input wire logic [`BUS_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [`BUS_W-1:0] RDATA,
    output logic TX_READY,
    input wire logic HALT,
    input wire logic RXD,
    output logic TXD,
    output logic IRQ
);
    localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] HALF_LAST = 16'(BIT_CYCLES / 2 - 1);

    // top index of the data field, parity included
    function automatic logic [3:0] field_top(input logic word9);
        field_top = word9 ? `TOP_9 : `TOP_8;
    endfunction

    // xor of the data bits that parity covers (7 or 8 low bits)
    function automatic logic low_xor(input logic [8:0] d, input logic word9);
        low_xor = word9 ? ^d[7:0] : ^d[6:0];
    endfunction

    // --- control and synchronised inputs ---
    logic [7:0] ctrl_q; // serial_control_one
    logic word9; // nine bit data field
    logic parity_control_enable; // parity on
    logic parity_odd_select; // odd parity when set
    logic wake_on_mark; // wake method select
    logic receiver_mute_request; // receiver asleep
    logic rxd_meta_q; // first sync stage, read only by second
    logic rxd_s_q; // synchronised line level

    assign word9 = ctrl_q[`CTL_WORD9];
    assign parity_control_enable = ctrl_q[`CTL_PCE];
    assign parity_odd_select = ctrl_q[`CTL_ODD];
    assign wake_on_mark = ctrl_q[`CTL_WAKE];
    assign receiver_mute_request = ctrl_q[`CTL_MUTE];

    // two stage synchroniser on the receive pin; idles high
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rxd_meta_q <= 1'b1;
            rxd_s_q <= 1'b1;
        end else begin
            rxd_meta_q <= RXD;
            rxd_s_q <= rxd_meta_q;
        end
    end

    // --- receive engine ---
    uart_mp_pkg::rx_state_t rx_state_q; // frame position
    logic [15:0] rx_cnt_q; // cycles within a bit
    logic [3:0] rx_idx_q; // field bit being sampled
    logic [8:0] rx_shift_q; // assembled field
    logic rx_done_q; // one cycle: frame ended
    logic rx_stop_ok_q; // stop bit seen high

    // mid-bit sampling; a start edge is checked again half a bit later
    // so that a glitch on the line does not start a frame
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rx_state_q <= uart_mp_pkg::RX_IDLE;
            rx_cnt_q <= 16'h0000;
            rx_idx_q <= 4'h0;
            rx_shift_q <= 9'h000;
            rx_done_q <= 1'b0;
            rx_stop_ok_q <= 1'b0;
        end else begin
            rx_done_q <= 1'b0;
            if (!HALT) begin
                case (rx_state_q)
                    uart_mp_pkg::RX_IDLE: begin
                        rx_cnt_q <= 16'h0000;
                        if (!rxd_s_q) begin
                            rx_state_q <= uart_mp_pkg::RX_START;
                        end
                    end
                    uart_mp_pkg::RX_START: begin
                        if (rx_cnt_q == HALF_LAST) begin
                            rx_cnt_q <= 16'h0000;
                            rx_idx_q <= 4'h0;
                            rx_shift_q <= 9'h000;
                            // false start returns to idle
                            rx_state_q <= rxd_s_q ? uart_mp_pkg::RX_IDLE
                                                  : uart_mp_pkg::RX_DATA;
                        end else begin
                            rx_cnt_q <= rx_cnt_q + 16'h0001;
                        end
                    end
                    uart_mp_pkg::RX_DATA: begin
                        if (rx_cnt_q == BIT_LAST) begin
                            rx_cnt_q <= 16'h0000;
                            rx_shift_q[rx_idx_q] <= rxd_s_q;
                            if (rx_idx_q == field_top(word9)) begin
                                rx_state_q <= uart_mp_pkg::RX_STOP;
                            end else begin
                                rx_idx_q <= rx_idx_q + 4'h1;
                            end
                        end else begin
                            rx_cnt_q <= rx_cnt_q + 16'h0001;
                        end
                    end
                    uart_mp_pkg::RX_STOP: begin
                        if (rx_cnt_q == BIT_LAST) begin
                            rx_cnt_q <= 16'h0000;
                            rx_stop_ok_q <= rxd_s_q;
                            rx_done_q <= 1'b1;
                            rx_state_q <= uart_mp_pkg::RX_IDLE;
                        end else begin
                            rx_cnt_q <= rx_cnt_q + 16'h0001;
                        end
                    end
                    default: begin
                        rx_state_q <= uart_mp_pkg::RX_IDLE;
                    end
                endcase
            end
        end
    end

    // --- idle line detector ---
    logic [15:0] idle_cyc_q; // cycles within one bit time
    logic [3:0] idle_bits_q; // whole bit times seen high
    logic idle_hold_q; // idle already reported for this gap
    logic idle_evt_q; // one cycle: idle line recognised

    // full character time high
    // held off after reset until the line has been active once,
    // so a quiet line at power-up raises no idle
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            idle_cyc_q <= 16'h0000;
            idle_bits_q <= 4'h0;
            idle_hold_q <= 1'b1;
            idle_evt_q <= 1'b0;
        end else begin
            idle_evt_q <= 1'b0;
            if (!HALT) begin
                if (!rxd_s_q || rx_state_q != uart_mp_pkg::RX_IDLE) begin
                    // any low level restarts the measurement
                    idle_cyc_q <= 16'h0000;
                    idle_bits_q <= 4'h0;
                    idle_hold_q <= 1'b0;
                end else if (!idle_hold_q) begin
                    if (idle_cyc_q == BIT_LAST) begin
                        idle_cyc_q <= 16'h0000;
                        // start, field and stop all seen high
                        if (idle_bits_q == field_top(word9) + `FRAME_EXTRA) begin
                            idle_evt_q <= 1'b1;
                            idle_hold_q <= 1'b1;
                        end else begin
                            idle_bits_q <= idle_bits_q + 4'h1;
                        end
                    end else begin
                        idle_cyc_q <= idle_cyc_q + 16'h0001;
                    end
                end
            end
        end
    end

    // --- reception decisions ---
    logic addr_mark; // waking word seen
    logic rx_parity_bad; // parity check failed
    logic rx_accept; // frame is received normally
    logic wake_idle; // idle line wake-up
    logic wake_mark; // address mark wake-up
    logic [4:0] flags_q; // sticky status flags
    logic [4:0] flag_set; // hardware sets
    logic [4:0] flag_clr; // software clears
    logic [8:0] rx_buf_q; // received data register
    logic bus_ok; // bus access allowed (not halted)

    // data msb, never the parity bit
    assign addr_mark = parity_control_enable
        ? (word9 ? rx_shift_q[7] : rx_shift_q[6])
        : (word9 ? rx_shift_q[8] : rx_shift_q[7]);

    // ones count with parity against select
    assign rx_parity_bad = parity_control_enable &&
        ((low_xor(rx_shift_q, word9) ^ rx_shift_q[field_top(word9)])
         != parity_odd_select);

    assign wake_idle = idle_evt_q && receiver_mute_request && !wake_on_mark;
    assign wake_mark = rx_done_q && receiver_mute_request && wake_on_mark
        && addr_mark;
    assign rx_accept = rx_done_q && (!receiver_mute_request || wake_mark);

    assign bus_ok = !HALT;

    // hardware set terms; a full buffer turns a new frame into overrun
    always_comb begin
        flag_set = 5'h00;
        flag_set[`ST_RX_DATA_READY_FLAG] = rx_accept;
        flag_set[`ST_IDLE] = idle_evt_q && !receiver_mute_request;
        flag_set[`ST_PERR] = rx_accept && !flags_q[`ST_RX_DATA_READY_FLAG] && rx_parity_bad;
        flag_set[`ST_OVR] = rx_accept && flags_q[`ST_RX_DATA_READY_FLAG];
        flag_set[`ST_FERR] = rx_accept && !flags_q[`ST_RX_DATA_READY_FLAG] && !rx_stop_ok_q;
    end

    // software clears: write one to status, reading data clears ready
    always_comb begin
        flag_clr = 5'h00;
        if (bus_ok && WR && ADDR == `REG_STAT) begin
            flag_clr = WDATA[4:0];
        end
        if (bus_ok && RD && ADDR == `REG_RXDATA) begin
            flag_clr[`ST_RX_DATA_READY_FLAG] = 1'b1;
        end
    end

    // sticky flags; a set in the clearing cycle wins
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            flags_q <= `FLAGS_RESET;
        end else begin
            flags_q <= flag_set | (flags_q & ~flag_clr);
        end
    end

    // data register keeps the older word on overrun
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rx_buf_q <= 9'h000;
        end else if (rx_accept && !flags_q[`ST_RX_DATA_READY_FLAG]) begin
            rx_buf_q <= rx_shift_q;
        end
    end

    // control register; a software write beats a hardware wake in the
    // same cycle so that a fresh mute request is never lost
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_q <= `CTL_RESET;
        end else if (bus_ok && WR && ADDR == `REG_CTRL) begin
            ctrl_q <= WDATA[7:0];
        end else if (wake_idle || wake_mark) begin
            ctrl_q[`CTL_MUTE] <= 1'b0;
        end
    end

    // --- transmit path ---
    uart_mp_pkg::tx_state_t tx_state_q; // transmitter state
    logic [10:0] tx_shift_q; // frame, lsb on the line
    logic [3:0] tx_bits_q; // bits left in frame
    logic [15:0] tx_cnt_q; // cycles within a bit
    logic fifo_valid; // a word waits
    logic fifo_pop; // transmitter takes it
    logic [8:0] fifo_data; // word to send
    logic [8:0] tx_field; // field with parity applied

    // word queue between the data register and the shifter
    uart_tx_fifo #(
        .WIDTH(`WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) tx_fifo (
        .clk(CORE_CLK),
        .rst_b(RST_B),
        .in_valid(bus_ok && WR && ADDR == `REG_TXDATA),
        .in_ready(TX_READY),
        .in_data(WDATA[8:0]),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    assign fifo_pop = fifo_valid && !HALT && tx_state_q == uart_mp_pkg::TX_IDLE;

    always_comb begin
        tx_field = fifo_data;
        if (parity_control_enable) begin
            tx_field[field_top(word9)] =
                low_xor(fifo_data, word9) ^ parity_odd_select;
        end
        // an eight bit field sends bit 8 as its stop level
        if (!word9) begin
            tx_field[8] = 1'b1;
        end
    end

    // shifter; the line idles high from reset
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            tx_state_q <= uart_mp_pkg::TX_IDLE;
            tx_shift_q <= 11'h7FF;
            tx_bits_q <= 4'h0;
            tx_cnt_q <= 16'h0000;
        end else if (!HALT) begin
            case (tx_state_q)
                uart_mp_pkg::TX_IDLE: begin
                    tx_cnt_q <= 16'h0000;
                    if (fifo_pop) begin
                        tx_shift_q <= {1'b1, tx_field, 1'b0};
                        tx_bits_q <= field_top(word9) + `FRAME_EXTRA + 4'h1;
                        tx_state_q <= uart_mp_pkg::TX_SHIFT;
                    end
                end
                uart_mp_pkg::TX_SHIFT: begin
                    if (tx_cnt_q == BIT_LAST) begin
                        tx_cnt_q <= 16'h0000;
                        tx_shift_q <= {1'b1, tx_shift_q[10:1]};
                        tx_bits_q <= tx_bits_q - 4'h1;
                        if (tx_bits_q == 4'h1) begin
                            tx_state_q <= uart_mp_pkg::TX_IDLE;
                        end
                    end else begin
                        tx_cnt_q <= tx_cnt_q + 16'h0001;
                    end
                end
                default: begin
                    tx_state_q <= uart_mp_pkg::TX_IDLE;
                end
            endcase
        end
    end

    assign TXD = tx_shift_q[0];

    // --- read port and interrupt request ---
    logic [`BUS_W-1:0] rdata_q; // read answer, one cycle after strobe
    logic [7:0] status; // live status view
    logic irq_q; // combined request

    always_comb begin
        status = {3'h0, flags_q};
        status[`ST_TXEMPTY] = !fifo_valid;
        status[`ST_TXDONE] = !fifo_valid && tx_state_q == uart_mp_pkg::TX_IDLE;
        status[`ST_RXBUSY] = rx_state_q != uart_mp_pkg::RX_IDLE;
    end

    // unmapped offsets and the write-only data register read zero
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_q <= '0;
        end else if (RD) begin
            case (ADDR)
                `REG_CTRL: rdata_q <= {8'h00, ctrl_q};
                `REG_STAT: rdata_q <= {8'h00, status};
                `REG_RXDATA: rdata_q <= {7'h00, rx_buf_q};
                default: rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign RDATA = rdata_q;

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= !receiver_mute_request && (
                (ctrl_q[`CTL_RIE] && (flags_q[`ST_RX_DATA_READY_FLAG] || flags_q[`ST_OVR])) ||
                (ctrl_q[`CTL_IIE] && flags_q[`ST_IDLE]) ||
                (ctrl_q[`CTL_PIE] && flags_q[`ST_PERR]));
        end
    end

    assign IRQ = irq_q;
endmodule
`default_nettype wire

// [sim/uart_mute_parity_assertions.sv]
// port assertions for the mute and parity serial block
`timescale 1ns/1ps
`default_nettype none
`include "uart_mp_params.svh"
module uart_mute_parity_checker #(
    parameter int BIT_CYCLES = `BIT_CYCLES_DEF
) (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic [`ADDR_W-1:0] ADDR,
    input wire logic [`BUS_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [`BUS_W-1:0] RDATA,
    input wire logic TX_READY,
    input wire logic HALT,
    input wire logic RXD,
    input wire logic TXD,
    input wire logic IRQ
);
    logic ctl_wr; // control write that takes effect
    logic txd_q; // line level at the last edge
    logic [15:0] run_q; // samples at this level, halt excluded
    logic [2:0] en_q; // shadow of the interrupt enables
    logic sent_q; // a word was accepted for sending
    assign ctl_wr = WR && !HALT && (ADDR == `REG_CTRL);
    // halt stretches a bit time, so halted cycles are not counted
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            txd_q <= 1'b1;
            run_q <= 16'h0000;
        end else begin
            txd_q <= TXD;
            run_q <= (TXD != txd_q) ? 16'h0001 : run_q + {15'h0000, !HALT};
        end
    end
    // shadows of what software has set up
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            en_q <= 3'h0;
            sent_q <= 1'b0;
        end else begin
            if (ctl_wr) begin
                en_q <= WDATA[7:5];
            end
            if (WR && !HALT && TX_READY && ADDR == `REG_TXDATA) begin
                sent_q <= 1'b1;
            end
        end
    end
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_B);
    AST_RDATA_QUIET:
        assert property (!$past(RD) |-> RDATA == 16'h0000)
        else $error("read data not zero outside a read answer");
    AST_RD_EMPTY_PLACE:
        assert property (RD && (ADDR == `REG_TXDATA || ADDR > `REG_RXDATA) |=> RDATA == 16'h0000)
        else $error("unmapped or write-only read gave data");
    AST_CTRL_READBACK:
        assert property (ctl_wr ##2 (RD && ADDR == `REG_CTRL) |=>
            RDATA[7:5] == $past(WDATA[7:5], 3) && RDATA[3:0] == $past(WDATA[3:0], 3))
        else $error("control bits do not read back");
    AST_HALT_TXD_FROZEN:
        assert property (HALT && $past(HALT) |-> $stable(TXD))
        else $error("line moved while halted");
    AST_MUTE_NO_IRQ:
        assert property (ctl_wr && WDATA[`CTL_MUTE] |-> ##2 !IRQ)
        else $error("interrupt while muted");
    AST_IRQ_NEEDS_ENABLE:
        assert property ($rose(IRQ) |-> (en_q | $past(en_q)) != 3'h0)
        else $error("interrupt with all enables clear");
    AST_TX_BIT_GRID:
        assert property (TXD && !txd_q |->
            run_q != 16'h0000 && run_q % BIT_CYCLES == 0 && run_q <= 10 * BIT_CYCLES)
        else $error("low run on line not whole bits of one frame");
    AST_TXD_RESTS_HIGH:
        assert property (!sent_q |-> TXD)
        else $error("line left idle level before any send");
endmodule
`default_nettype wire

// [sim/uart_line_partner.sv]
// far serial node: sends frames on rxd and decodes frames from txd
`timescale 1ns/1ps
`default_nettype none
module uart_line_partner #(
    parameter int BIT_CYCLES = 16
) (
    input wire logic clk,
    input wire logic txd,
    output logic rxd
);
    // line rests high between frames, as a pulled-up line would
    initial rxd = 1'b1;
    // start, field lsb first, stop; caller leaves idle after message
    task automatic send(input logic [8:0] field, input int nb);
        int i;
        @(posedge clk);
        rxd <= 1'b0;
        repeat (BIT_CYCLES) @(posedge clk);
        for (i = 0; i < nb; i++) begin
            rxd <= field[i];
            repeat (BIT_CYCLES) @(posedge clk);
        end
        rxd <= 1'b1;
        repeat (BIT_CYCLES) @(posedge clk);
    endtask
    // sample mid bit, well away from the edges
    task automatic recv(output logic [8:0] field, input int nb, output logic stop_ok);
        int i;
        field = 9'h000;
        @(negedge txd);
        repeat (BIT_CYCLES / 2) @(posedge clk);
        for (i = 0; i < nb; i++) begin
            repeat (BIT_CYCLES) @(posedge clk);
            field[i] = txd;
        end
        repeat (BIT_CYCLES) @(posedge clk);
        stop_ok = txd;
    endtask
endmodule
`default_nettype wire

// [sim/test_uart_mute_parity.sv]
// self-checking bench for the mute and parity serial block
`timescale 1ns/1ps
`default_nettype none
`include "uart_mp_params.svh"
module test_uart_mute_parity;
    localparam int BC = 4; // short bit time keeps the run brief
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic halt = 1'b0;
    logic [15:0] rdata;
    logic tx_ready, rxd, txd, irq, ok;
    int failures = 0;
    int checks_done = 0;
    int c, n;
    logic [15:0] rv;
    logic [8:0] f, got;
    logic [8:0] q[$];
    always #12.5 clk = ~clk;
    uart_mute_parity #(.BIT_CYCLES(BC), .FIFO_DEPTH(8)) dut (.CORE_CLK(clk), .RST_B(rst_b),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .TX_READY(tx_ready),
        .HALT(halt), .RXD(rxd), .TXD(txd), .IRQ(irq));
    uart_line_partner #(.BIT_CYCLES(BC)) far (.clk(clk), .txd(txd), .rxd(rxd));
    task automatic end_sim();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic ck(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic put(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic get(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    // data bits of a field for format {odd, parity on, nine bits}
    function automatic logic [8:0] dmask(input logic [2:0] cfg);
        return 9'h1FF >> (32'(!cfg[0]) + 32'(cfg[1]));
    endfunction
    // field on the line; bad flips the parity bit
    function automatic logic [8:0] mkf(input logic [8:0] w, input logic [2:0] cfg,
        input logic bad);
        logic [8:0] d;
        d = w & dmask(cfg);
        if (cfg[1]) d[cfg[0] ? 8 : 7] = ^d ^ cfg[2] ^ bad;
        return d;
    endfunction
    initial begin
        #(25 * 20000);
        failures++;
        end_sim();
    end
    initial begin
        void'($urandom(32'hF438));
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        get(`REG_CTRL, rv);
        ck(rv, 16'h0000);
        get(`REG_STAT, rv);
        ck(16'(rv[4:0]), 16'h0000);
        get(8'h5A, rv);
        ck(rv, 16'h0000);
        f = 9'($urandom) & 9'h0EF;
        put(`REG_CTRL, 16'(f));
        get(`REG_CTRL, rv);
        ck(16'(rv[7:0]), 16'(f[7:0]));
        // every format and both parity senses, each way
        for (c = 0; c < 8; c++) begin
            put(`REG_CTRL, 16'(c) | 16'h0020);
            f = 9'($urandom);
            put(`REG_TXDATA, 16'(f));
            far.recv(got, c[0] ? 9 : 8, ok);
            ck(16'(got), 16'(mkf(f, 3'(c), 1'b0)));
            ck(16'(ok), 16'h0001);
            far.send(mkf(f, 3'(c), ^c), c[0] ? 9 : 8);
            repeat (4) @(posedge clk);
            get(`REG_STAT, rv);
            ck({rv[2], rv[0]}, {c[1] & ^c, 1'b1});
            ck(16'(irq), 16'(c[1] & ^c));
            get(`REG_RXDATA, rv);
            ck(rv & 16'(dmask(3'(c))), 16'(f & dmask(3'(c))));
            put(`REG_STAT, 16'h001F);
        end
        repeat (12 * BC) @(posedge clk);
        // muted, idle flag left set: data msb low must not wake
        put(`REG_CTRL, 16'h00DA);
        far.send(9'h085, 8);
        repeat (4) @(posedge clk);
        get(`REG_STAT, rv);
        ck(16'(rv[4:0]), 16'h0002);
        ck(16'(irq), 16'h0000);
        far.send(9'h0C5, 8);
        repeat (4) @(posedge clk);
        get(`REG_CTRL, rv);
        ck(rv & 16'h0010, 16'h0000);
        get(`REG_STAT, rv);
        ck(16'(rv[0] & irq), 16'h0001);
        get(`REG_RXDATA, rv);
        ck(rv & 16'h007F, 16'h0045);
        repeat (12 * BC) @(posedge clk);
        put(`REG_STAT, 16'h001F);
        // idle wake: mute drops, no idle flag; next gap does flag
        put(`REG_CTRL, 16'h0090);
        far.send(9'($urandom), 8);
        repeat (12 * BC) @(posedge clk);
        get(`REG_CTRL, rv);
        ck(rv & 16'h00FF, 16'h0080);
        get(`REG_STAT, rv);
        ck(rv & 16'h001F, 16'h0000);
        far.send(9'($urandom), 8);
        repeat (12 * BC) @(posedge clk);
        get(`REG_STAT, rv);
        ck({rv[1:0], irq}, 16'h0007);
        @(posedge clk) halt <= 1'b1;
        put(`REG_CTRL, 16'h0001);
        get(`REG_CTRL, rv);
        @(posedge clk) halt <= 1'b0;
        ck(rv & 16'h00FF, 16'h0080);
        put(`REG_CTRL, 16'h0000);
        // fill until refused while the far end drains in order
        fork
            repeat (9) begin
                far.recv(got, 8, ok);
                ck(16'(got), 16'(q.pop_front()));
            end
            begin
                for (n = 0; n < 12 && tx_ready === 1'b1; n++) begin
                    f = 9'($urandom) & 9'h0FF;
                    q.push_back(f);
                    put(`REG_TXDATA, 16'(f));
                    @(negedge clk);
                end
                ck(16'(n), 16'h0009);
                put(`REG_TXDATA, 16'h01AA);
            end
        join
        end_sim();
    end
endmodule
bind uart_mute_parity uart_mute_parity_checker #(.BIT_CYCLES(BIT_CYCLES)) u_chk (
    .CORE_CLK(CORE_CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .TX_READY(TX_READY), .HALT(HALT), .RXD(RXD), .TXD(TXD), .IRQ(IRQ));
`default_nettype wire
